// [fan_gpio_config_regs.v]
// fan prescaler, dac/pwm drive and i/o configuration register bank
// Notes on behaviour
// - fan four prescale code at 1:0
// - fans five to seven at 3:2, 5:4, 7:6
// - two tach pulses per revolution assumed
// - manual mode drives dac from full byte
// - auto mode: dac upper nibble is minimum
// - pwm nibble is duty or auto minimum
// - pwm code maps to duty in fifteenths
// - bit0 selects io line 16 or alarm
// - writing one clears intrusion latch
// - bit2 selects 1.82 V or 2.5 V reference
// - bits 5:3 always read zero
// - bit6 sets io line 16 direction
// - bit7 sets io line 16 polarity
// - even bits set lines 0-3 direction
// - odd bits set lines 0-3 polarity
// - prescaler register resets to 55h
// - dac resets FFh, pwm F0h (duty code Fh), others 00h
// - config bit5 selects dac auto source
// - config bit6 selects pwm auto source
`timescale 1ns/1ns
`include "fan_gpio_map.vh"

module fan_gpio_config_regs
(
	input  wire        core_clk_in,            // system clock, 25 MHz
	input  wire        rst_in,                 // async reset, active high
	input  wire [7:0]  reg_addr_in,            // register offset
	input  wire [7:0]  reg_wdata_in,           // write data
	input  wire        reg_wr_in,              // write strobe, one cycle
	input  wire        reg_rd_in,              // read strobe, one cycle
	output reg  [7:0]  reg_rdata_out,          // read data, valid cycle after strobe
	output reg         reg_rvalid_out,         // read data valid pulse
	input  wire [7:0]  config_one_in,          // first configuration register value
	input  wire [7:0]  auto_dac_level_in,      // auto fan control dac demand
	input  wire [3:0]  auto_pwm_level_in,      // auto fan control pwm demand
	input  wire        intrusion_event_in,     // raw chassis intrusion pin
	output reg  [7:0]  fan_dac_out,            // fan speed dac code
	output reg         fan_pwm_out,            // pwm fan drive
	output wire [3:0]  tach_tick_out,          // tach measurement ticks, fans 4..7
	output reg         chassis_intrusion_latch_out, // latched intrusion flag
	output reg         shared_pin_is_io16_out, // 1: io line 16, 0: thermal alarm
	output reg         vref_high_out,          // 1: 2.5 V, 0: 1.82 V
	output reg         io16_dir_out,           // io line 16 direction, 1 output
	output reg         io16_pol_out,           // io line 16 polarity, 1 active high
	output reg  [3:0]  io_line_dir_out,        // lines 0..3 direction
	output reg  [3:0]  io_line_pol_out         // lines 0..3 polarity
);

	// stored registers
	reg [7:0]  fan_prescale_upper;   // fan 4..7 prescale codes
	reg [7:0]  fan_dac_level;        // dac value or auto minimum
	reg [3:0]  fan_pwm_duty;         // pwm nibble only; low bits not stored
	reg [7:0]  factory_reserved_one; // factory scratch byte
	reg [7:0]  misc_config_three;    // pin function, intrusion clear, vref, io16
	reg [7:0]  io_dir_pol_lines_0_3; // direction/polarity lines 0..3

	// pin synchroniser and pwm/tach timing
	reg        intr_meta;            // first sync stage, read only by intr_sync
	reg        intr_sync;            // synchronised intrusion level
	reg [`TACH_DIV_WIDTH-1:0] base_count; // base oscillator divider
	reg        base_tick;            // 22.5 kHz tick
	reg [3:0]  pwm_phase;            // position within 15-step period
	reg [3:0]  duty_code;            // effective pwm code
	reg [7:0]  next_dac;             // effective dac code
	reg [7:0]  next_rdata;           // read mux result
	wire       wr_misc;              // write to misc_config_three this cycle
	wire       intr_clear;           // clear request for the intrusion latch

	// reset code of the pwm duty field; the low nibble is never stored
	localparam [7:0]                 PWM_RST_BYTE  = `RST_FAN_PWM_DUTY;
	localparam [3:0]                 PWM_RST_CODE  = PWM_RST_BYTE[`PWM_FIELD_MSB:`PWM_FIELD_LSB];

	// last count of the base divider, cut to the counter width on purpose
	localparam integer               BASE_DIV_FULL = `TACH_BASE_DIV - 1;
	localparam [`TACH_DIV_WIDTH-1:0] BASE_LAST     = BASE_DIV_FULL[`TACH_DIV_WIDTH-1:0];

	assign wr_misc = reg_wr_in && (reg_addr_in == `OFS_MISC_CONFIG_THREE);

	// clear request: the stored bit holds the latch clear, the write edge clears at once
	assign intr_clear = misc_config_three[`BIT_INTRUSION_CLEAR]
		|| (wr_misc && reg_wdata_in[`BIT_INTRUSION_CLEAR]);

	// register writes; factory byte is writable but software must leave it alone
	// unmapped offsets are dropped silently; there is no error response
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			fan_prescale_upper   <= `RST_FAN_PRESCALE_UPPER;
			fan_dac_level        <= `RST_FAN_DAC_LEVEL;
			fan_pwm_duty         <= PWM_RST_CODE;
			factory_reserved_one <= `RST_FACTORY_RESERVED_ONE;
			misc_config_three    <= `RST_MISC_CONFIG_THREE;
			io_dir_pol_lines_0_3 <= `RST_IO_DIR_POL_LINES_0_3;
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				`OFS_FAN_PRESCALE_UPPER:   fan_prescale_upper   <= reg_wdata_in;
				`OFS_FAN_DAC_LEVEL:        fan_dac_level        <= reg_wdata_in;
				`OFS_FAN_PWM_DUTY:         fan_pwm_duty         <= reg_wdata_in[`PWM_FIELD_MSB:`PWM_FIELD_LSB];
				`OFS_FACTORY_RESERVED_ONE: factory_reserved_one <= reg_wdata_in;
				`OFS_MISC_CONFIG_THREE:    misc_config_three    <= reg_wdata_in & `MASK_MISC_CONFIG_THREE;
				`OFS_IO_DIR_POL_LINES_0_3: io_dir_pol_lines_0_3 <= reg_wdata_in;
				default:                   ; // unmapped offsets ignored
			endcase
		end
	end

	// read mux; unused pwm bits return zero, software ignores them
	// unmapped offsets read as zero rather than floating
	always @*
	begin
		case (reg_addr_in)
			`OFS_FAN_PRESCALE_UPPER:   next_rdata = fan_prescale_upper;
			`OFS_FAN_DAC_LEVEL:        next_rdata = fan_dac_level;
			`OFS_FAN_PWM_DUTY:         next_rdata = {fan_pwm_duty, 4'h0};
			`OFS_FACTORY_RESERVED_ONE: next_rdata = factory_reserved_one;
			`OFS_MISC_CONFIG_THREE:    next_rdata = misc_config_three & `MASK_MISC_CONFIG_THREE;
			`OFS_IO_DIR_POL_LINES_0_3: next_rdata = io_dir_pol_lines_0_3;
			default:                   next_rdata = 8'h00;
		endcase
	end

	// read data register, answered the cycle after the strobe
	// a read in the cycle of a write returns the value held before it
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			reg_rdata_out  <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end
		else
		begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in)
				reg_rdata_out <= next_rdata;
		end
	end

	// intrusion pin through two flops before use
	// the pin is asynchronous; only the second flop feeds the latch
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			intr_meta <= 1'b0;
			intr_sync <= 1'b0;
		end
		else
		begin
			intr_meta <= intrusion_event_in;
			intr_sync <= intr_meta;
		end
	end

	// intrusion latch; clear bit holds it clear while set, a new event still wins
	// set beats clear in one cycle, so no event is lost to a pending clear
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			chassis_intrusion_latch_out <= 1'b0;
		else if (intr_sync)
			chassis_intrusion_latch_out <= 1'b1;
		else if (intr_clear)
			chassis_intrusion_latch_out <= 1'b0;
	end

	// config outputs registered from the stored fields
	// outputs lag the register by one clock, so pins change only from flops
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			shared_pin_is_io16_out <= 1'b0;
			vref_high_out          <= 1'b0;
			io16_dir_out           <= 1'b0;
			io16_pol_out           <= 1'b0;
		end
		else
		begin
			shared_pin_is_io16_out <= misc_config_three[`BIT_PIN_IS_IO16];
			vref_high_out          <= misc_config_three[`BIT_VREF_HIGH];
			io16_dir_out           <= misc_config_three[`BIT_IO16_DIR];
			io16_pol_out           <= misc_config_three[`BIT_IO16_POL];
		end
	end

	// split direction/polarity pairs per line
	genvar li;
	generate
		for (li = 0; li < 4; li = li + 1)
		begin : g_line
			always @(posedge core_clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					io_line_dir_out[li] <= 1'b0;
					io_line_pol_out[li] <= 1'b0;
				end
				else
				begin
					io_line_dir_out[li] <= io_dir_pol_lines_0_3[2*li];
					io_line_pol_out[li] <= io_dir_pol_lines_0_3[2*li+1];
				end
			end
		end
	endgenerate

	// dac source: manual byte, or auto demand floored by upper nibble
	// the floor is the nibble at the top of the byte, its low bits zero
	always @*
	begin
		if (config_one_in[`BIT_DAC_AUTO])
		begin
			if (auto_dac_level_in < {fan_dac_level[7:4], 4'h0})
				next_dac = {fan_dac_level[7:4], 4'h0};
			else
				next_dac = auto_dac_level_in;
		end
		else
			next_dac = fan_dac_level;
	end

	// pwm source: manual nibble, or auto demand floored by nibble
	always @*
	begin
		if (config_one_in[`BIT_PWM_AUTO] && (auto_pwm_level_in > fan_pwm_duty))
			duty_code = auto_pwm_level_in;
		else
			duty_code = fan_pwm_duty;
	end

	// dac output register
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			fan_dac_out <= `RST_FAN_DAC_LEVEL;
		else
			fan_dac_out <= next_dac;
	end

	// pwm of 15 steps: high for code steps, so code/15 duty, 15 gives 100%
	// trade-off: a 15-clock period makes each code step exactly one fifteenth
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pwm_phase   <= 4'h0;
			fan_pwm_out <= 1'b1;
		end
		else
		begin
			if (pwm_phase >= `PWM_PERIOD_STEPS - 4'h1)
				pwm_phase <= 4'h0;
			else
				pwm_phase <= pwm_phase + 4'h1;
			fan_pwm_out <= (pwm_phase < duty_code);
		end
	end

	// base tach oscillator tick; count 153 at this rate is 8800 rpm with two pulses/rev
	// 25 MHz over 1111 lands within a tenth of a percent of 22.5 kHz
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			base_count <= {`TACH_DIV_WIDTH{1'b0}};
			base_tick  <= 1'b0;
		end
		else if (base_count == BASE_LAST)
		begin
			base_count <= {`TACH_DIV_WIDTH{1'b0}};
			base_tick  <= 1'b1;
		end
		else
		begin
			base_count <= base_count + {{(`TACH_DIV_WIDTH-1){1'b0}}, 1'b1};
			base_tick  <= 1'b0;
		end
	end

	// one prescaler per fan four to seven
	// a code change mid-period may shorten or stretch that one period
	genvar fi;
	generate
		for (fi = 0; fi < 4; fi = fi + 1)
		begin : g_fan
			tach_prescaler u_pre
			(
				.core_clk_in  (core_clk_in),
				.rst_in       (rst_in),
				.base_tick_in (base_tick),
				.code_in      (fan_prescale_upper[2*fi+1:2*fi]),
				.tick_out     (tach_tick_out[fi])
			);
		end
	endgenerate

endmodule // fan_gpio_config_regs

// [fan_gpio_config_regs_checker.sv]
// assertion checker for the fan and i/o configuration bank
`timescale 1ns/1ns
module fan_gpio_config_regs_checker
(
	input logic       core_clk_in,
	input logic       rst_in,
	input logic [7:0] reg_addr_in,
	input logic [7:0] reg_wdata_in,
	input logic       reg_wr_in,
	input logic       reg_rd_in,
	input logic       reg_rvalid_out,
	input logic [7:0] config_one_in,
	input logic       intrusion_event_in,
	input logic [7:0] fan_dac_out,
	input logic       chassis_intrusion_latch_out,
	input logic       shared_pin_is_io16_out,
	input logic       vref_high_out,
	input logic [3:0] io_line_dir_out,
	input logic [3:0] io_line_pol_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	logic [7:0] last_dac;  // last byte written to the dac register
	logic [7:0] wd1, wd2;  // write data two cycles back
	wire        w4 = reg_wr_in && reg_addr_in == 8'h04;
	// shadow of the dac byte, reset value full drive
	always_ff @(posedge core_clk_in or posedge rst_in)
		if (rst_in)
			last_dac <= 8'hFF;
		else if (w4)
			last_dac <= reg_wdata_in;
	// data pipe, matches the two-edge config latency
	always_ff @(posedge core_clk_in)
	begin
		wd1 <= reg_wdata_in;
		wd2 <= wd1;
	end
	a_rd_answer: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read strobe without valid");
	a_no_spurious: assert property (!reg_rd_in |=> !reg_rvalid_out)
		else $error("valid without read");
	a_pin_select: assert property (reg_wr_in && reg_addr_in == 8'h07 |=> ##1 shared_pin_is_io16_out == wd2[0])
		else $error("pin select mismatch");
	a_vref_select: assert property (reg_wr_in && reg_addr_in == 8'h07 |=> ##1 vref_high_out == wd2[2])
		else $error("vref select mismatch");
	a_line_dir: assert property (reg_wr_in && reg_addr_in == 8'h08 |=> ##1 io_line_dir_out == {wd2[6], wd2[4], wd2[2], wd2[0]})
		else $error("line direction mismatch");
	a_line_pol: assert property (reg_wr_in && reg_addr_in == 8'h08 |=> ##1 io_line_pol_out == {wd2[7], wd2[5], wd2[3], wd2[1]})
		else $error("line polarity mismatch");
	a_dac_manual: assert property ((!config_one_in[5] && !w4) [*4] |-> fan_dac_out == last_dac)
		else $error("manual dac mismatch");
	a_intr_set: assert property (intrusion_event_in [*4] |-> chassis_intrusion_latch_out)
		else $error("intrusion not latched");
	c_read: cover property (reg_rd_in ##1 reg_rvalid_out);
	c_latch: cover property ($rose(chassis_intrusion_latch_out));
	c_auto: cover property (config_one_in[5] && fan_dac_out == 8'h80);
endmodule // fan_gpio_config_regs_checker

// [fan_gpio_config_regs_test.sv]
// self-checking bench for the fan and i/o configuration bank
`timescale 1ns/1ns
`include "fan_gpio_map.vh"
module fan_gpio_config_regs_test;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] cfg1 = 8'h00;
	logic [7:0] adac = 8'h00;
	logic [3:0] apwm = 4'h0;
	logic       intr = 1'b0;
	logic [7:0] addr, wdata, rdata, dac, rv;
	logic       wr, rd, rvalid, pwm, latch, io16, vref, d16, p16, v;
	logic [3:0] tick, ldir, lpol;
	int         err_count = 0;
	int         checked = 0;
	fan_gpio_config_regs dut
	(
		.core_clk_in(clk),
		.rst_in(rst),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid),
		.config_one_in(cfg1),
		.auto_dac_level_in(adac),
		.auto_pwm_level_in(apwm),
		.intrusion_event_in(intr),
		.fan_dac_out(dac),
		.fan_pwm_out(pwm),
		.tach_tick_out(tick),
		.chassis_intrusion_latch_out(latch),
		.shared_pin_is_io16_out(io16),
		.vref_high_out(vref),
		.io16_dir_out(d16),
		.io16_pol_out(p16),
		.io_line_dir_out(ldir),
		.io_line_pol_out(lpol)
	);
	reg_host_model host
	(
		.core_clk_in(clk),
		.reg_rdata_in(rdata),
		.reg_rvalid_in(rvalid),
		.reg_addr_out(addr),
		.reg_wdata_out(wdata),
		.reg_wr_out(wr),
		.reg_rd_out(rd)
	);
	initial
		forever #20 clk = ~clk;
	task automatic chk(input logic [15:0] got, exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, e);
		host.rd(a, rv, v);
		chk({v, rv}, {1'b1, e});
	endtask
	// counts high samples of the pwm over one 15-clock period
	task automatic pwm_cnt(output int h);
		h = 0;
		repeat (30) @(posedge clk);
		repeat (15)
		begin
			@(posedge clk);
			#1;
			if (pwm === 1'b1)
				h++;
		end
	endtask
	task automatic t_reset;
		rchk(8'h03, 8'h55);
		rchk(8'h04, 8'hFF);
		host.rd(8'h05, rv, v);
		chk(rv[7:4], 4'hF);
		rchk(8'h06, 8'h00);
		rchk(8'h07, 8'h00);
		rchk(8'h08, 8'h00);
		rchk(8'h09, 8'h00);
		chk(dac, 8'hFF);
		chk(pwm, 1'b1);
		$display("reset values done");
	endtask
	task automatic t_cfg3;
		host.wr(8'h07, 8'hFD);
		rchk(8'h07, 8'hC5);
		chk({io16, vref, d16, p16}, 4'hF);
		host.wr(8'h07, 8'h00);
		@(posedge clk);
		#1;
		chk({io16, vref, d16, p16}, 4'h0);
		$display("config three done");
	endtask
	task automatic t_io;
		logic [7:0] d;
		d = 8'h5A;
		repeat (2)
		begin
			host.wr(8'h08, d);
			rchk(8'h08, d);
			chk(ldir, {d[6], d[4], d[2], d[0]});
			chk(lpol, {d[7], d[5], d[3], d[1]});
			d = ~d;
		end
		$display("line config done");
	endtask
	task automatic t_intr;
		intr = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		intr = 1'b0;
		chk(latch, 1'b1);
		host.wr(8'h07, 8'h02);
		repeat (3) @(posedge clk);
		#1;
		chk(latch, 1'b0);
		rchk(8'h07, 8'h02);
		host.wr(8'h07, 8'h00);
		$display("intrusion done");
	endtask
	task automatic t_drive;
		logic [3:0] c [5] = '{4'h0, 4'h1, 4'h5, 4'hE, 4'hF};
		int h;
		host.wr(8'h04, 8'h3C);
		repeat (4) @(posedge clk);
		#1;
		chk(dac, 8'h3C);
		cfg1 = 8'h20;
		adac = 8'h10;
		repeat (4) @(posedge clk);
		#1;
		chk(dac, 8'h30);
		adac = 8'h80;
		repeat (4) @(posedge clk);
		#1;
		chk(dac, 8'h80);
		cfg1 = 8'h00;
		foreach (c[i])
		begin
			host.wr(8'h05, {c[i], 4'hA});
			pwm_cnt(h);
			chk(h[15:0], c[i]);
		end
		cfg1 = 8'h40;
		apwm = 4'h9;
		host.wr(8'h05, 8'h50);
		pwm_cnt(h);
		chk(h[15:0], 16'h0009);
		apwm = 4'h3;
		pwm_cnt(h);
		chk(h[15:0], 16'h0005);
		$display("dac and pwm done");
	endtask
	task automatic t_tach;
		int n;
		host.wr(8'h03, 8'hE4);
		rchk(8'h03, 8'hE4);
		for (int i = 0; i < 4; i++)
		begin
			n = 0;
			while (tick[i] !== 1'b1)
				@(posedge clk) #1;
			do
			begin
				@(posedge clk);
				#1;
				n++;
			end while (tick[i] !== 1'b1 && n < 9000);
			chk(n[15:0], `TACH_BASE_DIV << i);
		end
		$display("tach prescale done");
	endtask
	// reset in mid-run must bring written registers back to power-on values
	task automatic t_rerun;
		host.wr(8'h03, 8'h00);
		host.wr(8'h04, 8'h00);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		rchk(8'h03, 8'h55);
		rchk(8'h04, 8'hFF);
		chk(dac, 8'hFF);
		$display("second reset done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset;
		t_cfg3;
		t_io;
		t_intr;
		t_drive;
		t_tach;
		t_rerun;
		conclude;
	end
	initial
	begin
		#3000000;
		err_count++;
		conclude;
	end
endmodule // fan_gpio_config_regs_test
bind fan_gpio_config_regs fan_gpio_config_regs_checker chk_i
(
	.core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rvalid_out, .config_one_in, .intrusion_event_in, .fan_dac_out,
	.chassis_intrusion_latch_out, .shared_pin_is_io16_out, .vref_high_out,
	.io_line_dir_out, .io_line_pol_out
);

// [fan_gpio_map.vh]
// register offsets, field positions, reset values and timing constants for the fan and i/o configuration bank
`ifndef FAN_GPIO_MAP_VH
`define FAN_GPIO_MAP_VH

// register offsets on the internal register port
`define OFS_FAN_PRESCALE_UPPER    8'h03
`define OFS_FAN_DAC_LEVEL         8'h04
`define OFS_FAN_PWM_DUTY          8'h05
`define OFS_FACTORY_RESERVED_ONE  8'h06
`define OFS_MISC_CONFIG_THREE     8'h07
`define OFS_IO_DIR_POL_LINES_0_3  8'h08

// power-on values
`define RST_FAN_PRESCALE_UPPER    8'h55
`define RST_FAN_DAC_LEVEL         8'hFF
`define RST_FAN_PWM_DUTY          8'hFF
`define RST_FACTORY_RESERVED_ONE  8'h00
`define RST_MISC_CONFIG_THREE     8'h00
`define RST_IO_DIR_POL_LINES_0_3  8'h00

// misc_config_three fields
`define BIT_PIN_IS_IO16           0
`define BIT_INTRUSION_CLEAR       1
`define BIT_VREF_HIGH             2
`define BIT_IO16_DIR              6
`define BIT_IO16_POL              7
`define MASK_MISC_CONFIG_THREE    8'hC7

// first configuration register fields (source selects)
`define BIT_DAC_AUTO              5
`define BIT_PWM_AUTO              6

// pwm field and period
`define PWM_FIELD_MSB             7
`define PWM_FIELD_LSB             4
`define PWM_PERIOD_STEPS          4'hF

// tach oscillator: 22.5 kHz base from 25 MHz core clock
`define TACH_BASE_HZ              22500
`define CORE_CLK_HZ               25000000
`define TACH_BASE_DIV             (`CORE_CLK_HZ / `TACH_BASE_HZ)
`define TACH_DIV_WIDTH            11

// tach pulses per revolution and nominal reference point
`define TACH_PULSES_PER_REV       2
`define TACH_REF_COUNT            153
`define TACH_REF_RPM_DIV1         8800

`endif

// [reg_host_model.sv]
// register port host model: one-cycle strobes, released lines inverted
`timescale 1ns/1ns
module reg_host_model
(
	input  logic       core_clk_in,
	input  logic [7:0] reg_rdata_in,
	input  logic       reg_rvalid_in,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic       reg_wr_out,
	output logic       reg_rd_out
);
	initial
	begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	// single byte write; the factory register is never touched
	task automatic wr(input logic [7:0] a, d);
		if (a != 8'h06)
		begin
			@(posedge core_clk_in);
			#1;
			reg_addr_out = a;
			reg_wdata_out = d;
			reg_wr_out = 1'b1;
			@(posedge core_clk_in);
			#1;
			reg_wr_out = 1'b0;
			reg_addr_out = ~a;
			reg_wdata_out = ~d;
		end
	endtask
	// single byte read, answer taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk_in);
		#1;
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(posedge core_clk_in);
		#1;
		v = reg_rvalid_in;
		d = reg_rdata_in;
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
	endtask
endmodule // reg_host_model

// [tach_prescaler.v]
// one fan's tach measurement clock prescaler, divide by 1, 2, 4 or 8 of the base tick
`timescale 1ns/1ns
`include "fan_gpio_map.vh"

module tach_prescaler
(
	input  wire       core_clk_in,  // system clock
	input  wire       rst_in,       // async reset, active high
	input  wire       base_tick_in, // one-cycle base oscillator tick
	input  wire [1:0] code_in,      // prescale code
	output reg        tick_out      // divided tick, one cycle
);

	reg [2:0] div_count; // counts base ticks within one divided period
	reg [2:0] div_limit; // last count before a divided tick

	// decode code into terminal count: 00->0, 01->1, 10->3, 11->7
	always @*
	begin
		case (code_in)
			2'b00:   div_limit = 3'h0;
			2'b01:   div_limit = 3'h1;
			2'b10:   div_limit = 3'h3;
			default: div_limit = 3'h7;
		endcase
	end

	// count base ticks; code changes take effect at the next wrap or sooner
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			div_count <= 3'h0;
			tick_out  <= 1'b0;
		end
		else
		begin
			tick_out <= 1'b0;
			if (base_tick_in)
			begin
				if (div_count >= div_limit)
				begin
					div_count <= 3'h0;
					tick_out  <= 1'b1;
				end
				else
					div_count <= div_count + 3'h1;
			end
		end
	end

endmodule // tach_prescaler
